// [verilog/qdrc_pkg.sv]
// package for the queued dma read command block
package qdrc_pkg;
    // ------------------------------------------------------------
    // register byte offsets on the bus
    // ------------------------------------------------------------
    localparam logic [7:0] QDRC_OFF_FEATURES = 8'h00;
    localparam logic [7:0] QDRC_OFF_SECTOR_TAG = 8'h04;
    localparam logic [7:0] QDRC_OFF_ADDR_LOW = 8'h08;
    localparam logic [7:0] QDRC_OFF_ADDR_MID = 8'h0c;
    localparam logic [7:0] QDRC_OFF_ADDR_HIGH = 8'h10;
    localparam logic [7:0] QDRC_OFF_DEVICE_SEL = 8'h14;
    localparam logic [7:0] QDRC_OFF_COMMAND = 8'h18;
    localparam logic [7:0] QDRC_OFF_ERROR = 8'h1c;
    localparam logic [7:0] QDRC_OFF_STATUS = 8'h20;
    localparam logic [7:0] QDRC_OFF_CONFIG = 8'h24;
    localparam logic [7:0] QDRC_OFF_MEDIA_EVT = 8'h28;
    localparam logic [7:0] QDRC_OFF_ENGINE = 8'h2c;
    localparam logic [7:0] QDRC_OFF_XFER_LEFT = 8'h30;
    // ------------------------------------------------------------
    // command codes and field positions
    // ------------------------------------------------------------
    localparam logic [7:0] QDRC_CMD_READ_QUEUED = 8'hc7;
    localparam logic [7:0] QDRC_CMD_SERVICE = 8'ha2;
    localparam logic [7:0] QDRC_CMD_MEDIA_QUERY = 8'hda;
    localparam int QDRC_TAG_LSB = 3;
    localparam int QDRC_REL_BIT = 2;
    localparam int QDRC_IO_BIT = 1;
    localparam int QDRC_CD_BIT = 0;
    localparam int QDRC_DEV_LBA_BIT = 6;
    localparam int QDRC_DEV_SEL_BIT = 4;
    localparam logic [8:0] QDRC_MAX_SECTORS = 9'h100;
    localparam logic [7:0] QDRC_RESET_BYTE = 8'h00;
    localparam logic [7:0] QDRC_STATUS_RESET = 8'h40;
    // status bit positions
    localparam int QDRC_ST_BUSY = 7;
    localparam int QDRC_ST_READY = 6;
    localparam int QDRC_ST_FAULT = 5;
    localparam int QDRC_ST_SERVICE_PENDING_FLAG = 4;
    localparam int QDRC_ST_DRQ = 3;
    localparam int QDRC_ST_ERR = 0;
    // error bit positions
    localparam int QDRC_ER_CRC = 7;
    localparam int QDRC_ER_UNC = 6;
    localparam int QDRC_ER_MC = 5;
    localparam int QDRC_ER_ADDRESS_NOT_FOUND_ERROR = 4;
    localparam int QDRC_ER_MCR = 3;
    localparam int QDRC_ER_COMMAND_ABORTED_FLAG = 2;
    localparam int QDRC_ER_NM = 1;
    // ------------------------------------------------------------
    // types
    // ------------------------------------------------------------
    typedef enum logic [4:0] {
        QDRC_IDLE = 5'b00001,
        QDRC_RELEASED = 5'b00010,
        QDRC_SERVICE_PENDING_FLAG_WAIT = 5'b00100,
        QDRC_XFER = 5'b01000,
        QDRC_DONE = 5'b10000
    } qdrc_state_t;
    // engine events from the media side, one-cycle pulses
    typedef struct packed {
        logic data_ready;
        logic xfer_done;
        logic fail;
        logic crc_err;
        logic unc_err;
        logic not_found;
        logic out_of_range;
        logic udma_err;
        logic dev_fault;
        logic [27:0] fail_addr;
    } qdrc_engine_t;
endpackage

// [verilog/qdrc_ahb_slave.sv]
// ahb-lite slave front end, registers one access into a simple strobe
`timescale 1ns/1ps
module qdrc_ahb_slave (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    output logic WR_STB,
    output logic RD_STB,
    output logic [7:0] ACC_ADDR,
    output logic [7:0] WR_DATA,
    input wire logic [7:0] RD_DATA
);
    logic pend_wr_q;
    logic pend_rd_q;
    logic [7:0] addr_q;
    logic [31:0] rdata_q;
    logic take;

    // ------------------------------------------------------------
    // address phase capture
    // ------------------------------------------------------------
    assign take = HSEL && HREADY && HTRANS[1];
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            pend_wr_q <= 1'b0;
            pend_rd_q <= 1'b0;
            addr_q <= 8'h00;
        end else if (HREADY) begin
            pend_wr_q <= take && HWRITE;
            pend_rd_q <= take && !HWRITE;
            addr_q <= HADDR[7:0];
        end
    end

    // read data is sampled in the data phase, write lands then too
    assign WR_STB = pend_wr_q;
    assign RD_STB = pend_rd_q;
    assign ACC_ADDR = addr_q;
    assign WR_DATA = HWDATA[7:0];
    assign HREADYOUT = 1'b1; // zero wait states
    assign HRESP = 1'b0;
    always_comb begin
        rdata_q = {24'h000000, RD_DATA};
    end
    assign HRDATA = rdata_q;
endmodule

// [verilog/qdrc_top.sv]
// queued dma read command interpreter, device side
`timescale 1ns/1ps
// Function
// - features gives sector count, zero means 256 sectors
// - data may move at once or after the resume command
// - transfer image: tag, release clear, direction one, command/data clear
// - transfer status: busy clear, ready, no fault, data request, no check
// - transfer status shows service pending if another command waits
// - release image: tag, release set, direction and command/data clear
// - release status: busy clear, ready, no fault, no request, no error
// - release service pending set when another waits or this prepared
// - after release, ready device sets only service pending
// - resume command shows the transfer image only
// - completion: error cleared, tag, release clear, direction and c/d set
// - completion status: ready only, service pending from queue
// - abort when unsupported or overlapped interrupt disabled
// - abort on invalid tag when queuing supported
// - unrecoverable error loads failing address and aborts queue
// - crc bit on ultra dma crc error, uncorrectable bit on bad data
// - not found or abort for bad address, abort for dma errors
// - media changed, change request, no media reported; request sticky
// - error status: ready, fault if faulted, error if any bit set
// - error image: tag, release clear, direction and c/d set
// - device releases bus or transfers at once if data ready
module qdrc_top (
    input wire logic CLK,
    input wire logic SYS_RST,
    input wire logic HSEL,
    input wire logic [31:0] HADDR,
    input wire logic [1:0] HTRANS,
    input wire logic HWRITE,
    input wire logic [2:0] HSIZE,
    input wire logic [31:0] HWDATA,
    input wire logic HREADY,
    output logic HREADYOUT,
    output logic HRESP,
    output logic [31:0] HRDATA,
    input wire qdrc_pkg::qdrc_engine_t ENGINE_EVT,
    input wire logic MEDIA_CHANGED,
    input wire logic MEDIA_CHANGE_REQ,
    input wire logic NO_MEDIA,
    input wire logic OTHER_QUEUED,
    output logic CMD_START,
    output logic [27:0] CMD_ADDR,
    output logic [8:0] CMD_SECTORS,
    output logic [4:0] CMD_TAG,
    output logic DMA_ENABLE,
    output logic QUEUE_ABORT
);
    logic wr_stb, rd_stb;
    logic [7:0] acc_addr, wr_data, rd_data;
    logic [7:0] features_q, sector_tag_q, addr_low_q, addr_mid_q, addr_high_q;
    logic [7:0] device_q, error_q, status_q, config_q;
    logic mc_state_q, mcr_q, start_q, abort_q, queued_q;
    logic [4:0] tag_q;
    logic [8:0] sectors_q;
    logic [27:0] cmd_addr_q;
    qdrc_pkg::qdrc_state_t state_q;
    logic cmd_wr, is_read_cmd, is_service, cmd_ok;
    logic [7:0] err_bits;
    logic [4:0] tag_shown;

    qdrc_ahb_slave u_slave (
        .CLK(CLK),
        .SYS_RST(SYS_RST),
        .HSEL(HSEL),
        .HADDR(HADDR),
        .HTRANS(HTRANS),
        .HWRITE(HWRITE),
        .HSIZE(HSIZE),
        .HWDATA(HWDATA),
        .HREADY(HREADY),
        .HREADYOUT(HREADYOUT),
        .HRESP(HRESP),
        .HRDATA(HRDATA),
        .WR_STB(wr_stb),
        .RD_STB(rd_stb),
        .ACC_ADDR(acc_addr),
        .WR_DATA(wr_data),
        .RD_DATA(rd_data)
    );

    // ------------------------------------------------------------
    // decode helpers
    // ------------------------------------------------------------
    // zero in the count field stands for the full 256 sectors
    function automatic logic [8:0] qdrc_count(input logic [7:0] f);
        qdrc_count = (f == 8'h00) ? qdrc_pkg::QDRC_MAX_SECTORS : {1'b0, f};
    endfunction

    assign cmd_wr = wr_stb && (acc_addr == qdrc_pkg::QDRC_OFF_COMMAND);
    // a new command is only taken while no other one is in flight
    assign is_read_cmd = cmd_wr && state_q == qdrc_pkg::QDRC_IDLE
        && (wr_data == qdrc_pkg::QDRC_CMD_READ_QUEUED);
    assign is_service = cmd_wr && (wr_data == qdrc_pkg::QDRC_CMD_SERVICE);
    // config: bit0 queuing supported, bit1 overlap enabled, bit2 command supported
    // tag mask bits 7:3 give the highest valid tag when queuing
    assign cmd_ok = config_q[2] && config_q[1] &&
        (!config_q[0] || sector_tag_q[7:3] <= config_q[7:3]);
    assign tag_shown = (config_q[0] && config_q[1]) ? tag_q : 5'h00;

    // ------------------------------------------------------------
    // host written input registers
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            features_q <= qdrc_pkg::QDRC_RESET_BYTE;
            config_q <= qdrc_pkg::QDRC_RESET_BYTE;
        end else if (wr_stb) begin
            if (acc_addr == qdrc_pkg::QDRC_OFF_FEATURES) begin
                features_q <= wr_data;
            end
            if (acc_addr == qdrc_pkg::QDRC_OFF_CONFIG) begin
                config_q <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // command block registers: host writes, device images
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            sector_tag_q <= qdrc_pkg::QDRC_RESET_BYTE;
            addr_low_q <= qdrc_pkg::QDRC_RESET_BYTE;
            addr_mid_q <= qdrc_pkg::QDRC_RESET_BYTE;
            addr_high_q <= qdrc_pkg::QDRC_RESET_BYTE;
            device_q <= qdrc_pkg::QDRC_RESET_BYTE;
        end else if (state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.fail) begin
            // first failing address back into the address registers
            sector_tag_q <= {tag_shown, 3'b011};
            addr_low_q <= ENGINE_EVT.fail_addr[7:0];
            addr_mid_q <= ENGINE_EVT.fail_addr[15:8];
            addr_high_q <= ENGINE_EVT.fail_addr[23:16];
            device_q <= {3'b000, device_q[qdrc_pkg::QDRC_DEV_SEL_BIT],
                ENGINE_EVT.fail_addr[27:24]};
        end else if (state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.xfer_done) begin
            sector_tag_q <= {tag_shown, 3'b011};
            device_q <= {3'b000, device_q[qdrc_pkg::QDRC_DEV_SEL_BIT], 4'h0};
        end else if ((start_q && !abort_q && ENGINE_EVT.data_ready)
            || (state_q == qdrc_pkg::QDRC_SERVICE_PENDING_FLAG_WAIT && is_service)) begin
            sector_tag_q <= {tag_shown, 3'b010};
            device_q <= {3'b000, device_q[qdrc_pkg::QDRC_DEV_SEL_BIT], 4'h0};
        end else if (state_q == qdrc_pkg::QDRC_IDLE && start_q && !abort_q) begin
            sector_tag_q <= {tag_shown, 3'b100};
            device_q <= {3'b000, device_q[qdrc_pkg::QDRC_DEV_SEL_BIT], 4'h0};
        end else if (wr_stb && state_q == qdrc_pkg::QDRC_IDLE) begin
            // host loads tag, address and device select
            if (acc_addr == qdrc_pkg::QDRC_OFF_SECTOR_TAG) begin
                sector_tag_q <= wr_data;
            end
            if (acc_addr == qdrc_pkg::QDRC_OFF_ADDR_LOW) begin
                addr_low_q <= wr_data;
            end
            if (acc_addr == qdrc_pkg::QDRC_OFF_ADDR_MID) begin
                addr_mid_q <= wr_data;
            end
            if (acc_addr == qdrc_pkg::QDRC_OFF_ADDR_HIGH) begin
                addr_high_q <= wr_data;
            end
            if (acc_addr == qdrc_pkg::QDRC_OFF_DEVICE_SEL) begin
                device_q <= wr_data;
            end
        end
    end

    // ------------------------------------------------------------
    // command acceptance
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            start_q <= 1'b0;
            abort_q <= 1'b0;
            tag_q <= 5'h00;
            sectors_q <= 9'h000;
            cmd_addr_q <= 28'h0000000;
            queued_q <= 1'b0;
        end else begin
            start_q <= is_read_cmd && state_q == qdrc_pkg::QDRC_IDLE
                && status_q[qdrc_pkg::QDRC_ST_READY];
            abort_q <= is_read_cmd && !cmd_ok;
            queued_q <= state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.fail;
            if (is_read_cmd) begin
                tag_q <= config_q[0] ? sector_tag_q[7:3] : 5'h00;
                sectors_q <= qdrc_count(features_q);
                // keep the start address, the registers get overwritten by images
                cmd_addr_q <= {device_q[3:0], addr_high_q, addr_mid_q, addr_low_q};
            end
        end
    end

    // ------------------------------------------------------------
    // command sequence
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            state_q <= qdrc_pkg::QDRC_IDLE;
        end else begin
            case (state_q)
                qdrc_pkg::QDRC_IDLE: begin
                    if (start_q && !abort_q) begin
                        // release first unless data is already at hand
                        state_q <= ENGINE_EVT.data_ready ? qdrc_pkg::QDRC_XFER
                            : qdrc_pkg::QDRC_RELEASED;
                    end
                end
                qdrc_pkg::QDRC_RELEASED: begin
                    if (ENGINE_EVT.data_ready) begin
                        state_q <= qdrc_pkg::QDRC_SERVICE_PENDING_FLAG_WAIT;
                    end
                end
                qdrc_pkg::QDRC_SERVICE_PENDING_FLAG_WAIT: begin
                    if (is_service) begin
                        state_q <= qdrc_pkg::QDRC_XFER;
                    end
                end
                qdrc_pkg::QDRC_XFER: begin
                    if (ENGINE_EVT.fail || ENGINE_EVT.xfer_done) begin
                        state_q <= qdrc_pkg::QDRC_DONE;
                    end
                end
                qdrc_pkg::QDRC_DONE: begin
                    state_q <= qdrc_pkg::QDRC_IDLE;
                end
                default: begin
                    state_q <= qdrc_pkg::QDRC_IDLE;
                end
            endcase
        end
    end

    // ------------------------------------------------------------
    // error register
    // ------------------------------------------------------------
    always_comb begin
        err_bits = 8'h00;
        err_bits[qdrc_pkg::QDRC_ER_CRC] = ENGINE_EVT.crc_err;
        err_bits[qdrc_pkg::QDRC_ER_UNC] = ENGINE_EVT.unc_err;
        err_bits[qdrc_pkg::QDRC_ER_MC] = mc_state_q;
        err_bits[qdrc_pkg::QDRC_ER_ADDRESS_NOT_FOUND_ERROR] = ENGINE_EVT.not_found;
        err_bits[qdrc_pkg::QDRC_ER_MCR] = mcr_q;
        err_bits[qdrc_pkg::QDRC_ER_COMMAND_ABORTED_FLAG] = ENGINE_EVT.out_of_range
            || ENGINE_EVT.udma_err || ENGINE_EVT.crc_err;
        err_bits[qdrc_pkg::QDRC_ER_NM] = NO_MEDIA;
    end

    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            error_q <= qdrc_pkg::QDRC_RESET_BYTE;
        end else if (abort_q) begin
            error_q <= 8'h04;
        end else if (state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.fail) begin
            error_q <= err_bits;
        end else if (state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.xfer_done) begin
            error_q <= 8'h00;
        end
    end

    // media change state: set wins over the clear by report or query
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            mc_state_q <= 1'b0;
            mcr_q <= 1'b0;
        end else begin
            if (MEDIA_CHANGED) begin
                mc_state_q <= 1'b1;
            end else if (state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.fail) begin
                mc_state_q <= 1'b0;
            end
            if (MEDIA_CHANGE_REQ) begin
                mcr_q <= 1'b1;
            end else if (cmd_wr && wr_data == qdrc_pkg::QDRC_CMD_MEDIA_QUERY) begin
                mcr_q <= 1'b0;
            end else if (start_q && !abort_q) begin
                mcr_q <= 1'b0;
            end
        end
    end

    // ------------------------------------------------------------
    // status register images
    // ------------------------------------------------------------
    always_ff @(posedge CLK or posedge SYS_RST) begin
        if (SYS_RST) begin
            status_q <= qdrc_pkg::QDRC_STATUS_RESET;
        end else if (is_read_cmd) begin
            status_q <= 8'h80; // busy while deciding
        end else if (abort_q) begin
            status_q <= {2'b01, 1'b0, OTHER_QUEUED, 3'b000, 1'b1};
        end else if (state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.fail) begin
            status_q <= {2'b01, ENGINE_EVT.dev_fault, OTHER_QUEUED, 3'b000,
                |err_bits};
        end else if (state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.xfer_done) begin
            status_q <= {2'b01, 1'b0, OTHER_QUEUED, 4'b0000};
        end else if (start_q && ENGINE_EVT.data_ready) begin
            status_q <= {2'b01, 1'b0, OTHER_QUEUED, 1'b1, 3'b000};
        end else if (start_q) begin
            status_q <= {2'b01, 1'b0, OTHER_QUEUED, 4'b0000};
        end else if (state_q == qdrc_pkg::QDRC_RELEASED && ENGINE_EVT.data_ready) begin
            status_q[qdrc_pkg::QDRC_ST_SERVICE_PENDING_FLAG] <= 1'b1;
        end else if (state_q == qdrc_pkg::QDRC_SERVICE_PENDING_FLAG_WAIT && is_service) begin
            status_q <= {2'b01, 1'b0, OTHER_QUEUED, 1'b1, 3'b000};
        end else if (state_q == qdrc_pkg::QDRC_XFER) begin
            status_q[qdrc_pkg::QDRC_ST_SERVICE_PENDING_FLAG] <= OTHER_QUEUED;
        end
    end

    // ------------------------------------------------------------
    // read mux and engine outputs
    // ------------------------------------------------------------
    always_comb begin
        case (acc_addr)
            qdrc_pkg::QDRC_OFF_SECTOR_TAG: rd_data = sector_tag_q;
            qdrc_pkg::QDRC_OFF_ADDR_LOW: rd_data = addr_low_q;
            qdrc_pkg::QDRC_OFF_ADDR_MID: rd_data = addr_mid_q;
            qdrc_pkg::QDRC_OFF_ADDR_HIGH: rd_data = addr_high_q;
            qdrc_pkg::QDRC_OFF_DEVICE_SEL: rd_data = device_q;
            qdrc_pkg::QDRC_OFF_ERROR: rd_data = error_q;
            qdrc_pkg::QDRC_OFF_STATUS: rd_data = status_q;
            qdrc_pkg::QDRC_OFF_CONFIG: rd_data = config_q;
            qdrc_pkg::QDRC_OFF_ENGINE: rd_data = {3'b000, state_q};
            default: rd_data = 8'h00;
        endcase
    end

    assign CMD_START = start_q && !abort_q;
    assign CMD_ADDR = cmd_addr_q;
    assign CMD_SECTORS = sectors_q;
    assign CMD_TAG = tag_q;
    assign DMA_ENABLE = state_q == qdrc_pkg::QDRC_XFER;
    assign QUEUE_ABORT = queued_q;

    // ------------------------------------------------------------
    // checks
    // ------------------------------------------------------------
    a_abort_sets_err: assert property (@(posedge CLK) disable iff (SYS_RST)
        abort_q |=> error_q[qdrc_pkg::QDRC_ER_COMMAND_ABORTED_FLAG] && status_q[0])
        else $error("abort did not flag error");
    a_xfer_drq_set: assert property (@(posedge CLK) disable iff (SYS_RST)
        start_q && !abort_q && ENGINE_EVT.data_ready |=> status_q[3] && !status_q[7])
        else $error("transfer image lacks data request");
    a_release_rel: assert property (@(posedge CLK) disable iff (SYS_RST)
        start_q && !abort_q && !ENGINE_EVT.data_ready && state_q == qdrc_pkg::QDRC_IDLE
        |=> sector_tag_q[2:0] == 3'b100)
        else $error("release image wrong");
    a_done_error_clr: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.xfer_done && !ENGINE_EVT.fail
        |=> error_q == 8'h00 && sector_tag_q[1:0] == 2'b11)
        else $error("completion image wrong");
    a_fail_addr: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_q == qdrc_pkg::QDRC_XFER && ENGINE_EVT.fail
        |=> addr_low_q == $past(ENGINE_EVT.fail_addr[7:0]) && QUEUE_ABORT)
        else $error("failing address not loaded");
    a_zero_count: assert property (@(posedge CLK) disable iff (SYS_RST)
        is_read_cmd && features_q == 8'h00 |=> sectors_q == 9'h100)
        else $error("zero count not 256");
    a_service_pending_flag_only: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_q == qdrc_pkg::QDRC_RELEASED && ENGINE_EVT.data_ready && !cmd_wr
        |=> status_q[4] && $stable(sector_tag_q))
        else $error("service request changed other bits");
    a_bad_tag: assert property (@(posedge CLK) disable iff (SYS_RST)
        is_read_cmd && config_q[0] && sector_tag_q[7:3] > config_q[7:3]
        |=> abort_q)
        else $error("invalid tag not aborted");
    a_resume_image: assert property (@(posedge CLK) disable iff (SYS_RST)
        state_q == qdrc_pkg::QDRC_SERVICE_PENDING_FLAG_WAIT && is_service
        |=> sector_tag_q[2:0] == 3'b010 && status_q[3] && !status_q[7])
        else $error("resume did not show transfer image");
endmodule

// [testbench/qdrc_host_model.sv]
// host adapter model driving the ahb-lite register bus
`timescale 1ns/1ps
module qdrc_host_model (
    input wire logic CLK,
    input wire logic HREADY,
    input wire logic [31:0] HRDATA,
    output logic HSEL,
    output logic [31:0] HADDR,
    output logic [1:0] HTRANS,
    output logic HWRITE,
    output logic [2:0] HSIZE,
    output logic [31:0] HWDATA
);
    // idle bus at time zero, always word sized
    initial begin
        HSEL = 1'b1;
        HADDR = '0;
        HTRANS = 2'h0;
        HWRITE = 1'b0;
        HSIZE = 3'h2;
        HWDATA = '0;
    end
    // single transfer, each phase held until hready is seen high
    task xfer(input logic w, input logic [7:0] a, input logic [7:0] d, output logic [7:0] r);
        @(posedge CLK);
        HTRANS <= 2'h2;
        HADDR <= {24'h000000, a};
        HWRITE <= w;
        do @(posedge CLK); while (HREADY !== 1'b1);
        HTRANS <= 2'h0;
        HWDATA <= {24'h000000, d};
        do @(posedge CLK); while (HREADY !== 1'b1);
        r = HRDATA[7:0];
    endtask
endmodule

// [testbench/qdrc_top_tb.sv]
// self-checking testbench for the queued dma read command block
`timescale 1ns/1ps
module qdrc_top_tb;
    logic CLK, SYS_RST, HSEL, HWRITE, HRDY, HRESP, oq, qa, qa_seen, cst, dma;
    logic [31:0] HADDR, HWDATA, HRDATA;
    logic [1:0] HTRANS;
    logic [2:0] HSIZE;
    logic [27:0] ca;
    logic [8:0] cs;
    logic [4:0] ct;
    qdrc_pkg::qdrc_engine_t eng, e;
    int error_cnt = 0;
    int compares = 0;
    int starts = 0;
    qdrc_top DUT (.CLK(CLK), .SYS_RST(SYS_RST), .HSEL(HSEL), .HADDR(HADDR), .HTRANS(HTRANS),
        .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA), .HREADY(HRDY), .HREADYOUT(HRDY),
        .HRESP(HRESP), .HRDATA(HRDATA), .ENGINE_EVT(eng), .MEDIA_CHANGED(1'b0),
        .MEDIA_CHANGE_REQ(1'b0), .NO_MEDIA(1'b0), .OTHER_QUEUED(oq), .CMD_START(cst),
        .CMD_ADDR(ca), .CMD_SECTORS(cs), .CMD_TAG(ct), .DMA_ENABLE(dma), .QUEUE_ABORT(qa));
    qdrc_host_model host (.CLK(CLK), .HREADY(HRDY), .HRDATA(HRDATA), .HSEL(HSEL),
        .HADDR(HADDR), .HTRANS(HTRANS), .HWRITE(HWRITE), .HSIZE(HSIZE), .HWDATA(HWDATA));
    // 40 mhz clock
    initial begin
        CLK = 1'b0;
        forever #12.5 CLK = ~CLK;
    end
    // remember the queue abort pulse
    always @(posedge CLK) if (qa === 1'b1) qa_seen <= 1'b1;
    // count accepted commands
    always @(posedge CLK) if (cst === 1'b1) starts <= starts + 1;
    task chk(input logic [31:0] g, input logic [31:0] x);
        compares++;
        if (g !== x) begin
            error_cnt++;
            $display("Error at %0t: got %h exp %h", $time, g, x);
        end
    endtask
    task rd(input logic [7:0] a, input logic [7:0] x);
        logic [7:0] r;
        host.xfer(1'b0, a, 8'h00, r);
        chk({24'h000000, r}, {24'h000000, x});
    endtask
    task wr(input logic [7:0] a, input logic [7:0] d);
        logic [7:0] r;
        host.xfer(1'b1, a, d, r);
        repeat (3) @(posedge CLK);
    endtask
    // one engine pulse, failing address kept as a level
    task ev(input qdrc_pkg::qdrc_engine_t v);
        eng <= v;
        @(posedge CLK);
        eng <= {9'h000, v.fail_addr};
        repeat (2) @(posedge CLK);
    endtask
    task cmd(input logic [7:0] cfg, input logic [7:0] sc);
        wr(8'h24, cfg);
        wr(8'h00, 8'h00);
        wr(8'h04, sc);
        wr(8'h08, 8'h21);
        wr(8'h0c, 8'h43);
        wr(8'h10, 8'h65);
        wr(8'h14, 8'h57);
        wr(8'h18, 8'hc7);
    endtask
    // data ready after release, then the resume command
    task service_pending_flag;
        e = '0;
        e.data_ready = 1'b1;
        ev(e);
        rd(8'h20, 8'h50);
        wr(8'h18, 8'ha2);
    endtask
    task t_abort;
        cmd(8'h00, 8'h00);
        rd(8'h1c, 8'h04);
        rd(8'h20, 8'h41);
        cmd(8'h1f, 8'h28);
        rd(8'h1c, 8'h04);
        rd(8'h20, 8'h41);
        chk(starts, 32'h0);
        $display("abort test done");
    endtask
    task t_release;
        cmd(8'hff, 8'h28);
        chk(32'(cs), 32'h100);
        chk(32'(ca), 32'h7654321);
        chk(32'(ct), 32'h5);
        chk(starts, 32'h1);
        chk(32'(HRESP), 32'h0);
        rd(8'h04, 8'h2c);
        rd(8'h20, 8'h40);
        oq <= 1'b1;
        service_pending_flag;
        rd(8'h04, 8'h2a);
        rd(8'h20, 8'h58);
        chk(32'(dma), 32'h1);
        e = '0;
        e.xfer_done = 1'b1;
        ev(e);
        rd(8'h1c, 8'h00);
        rd(8'h04, 8'h2b);
        rd(8'h20, 8'h50);
        $display("release test done");
    endtask
    task t_error;
        cmd(8'hff, 8'h08);
        service_pending_flag;
        e = '0;
        e.fail = 1'b1;
        e.unc_err = 1'b1;
        e.dev_fault = 1'b1;
        e.fail_addr = 28'h9abcdef;
        ev(e);
        chk(32'(qa_seen), 32'h1);
        rd(8'h1c, 8'h40);
        rd(8'h08, 8'hef);
        rd(8'h10, 8'hab);
        rd(8'h04, 8'h0b);
        rd(8'h20, 8'h71);
        $display("error test done");
    endtask
    // data already at hand at acceptance: no release, transfer at once
    task t_direct;
        e = '0;
        e.data_ready = 1'b1;
        eng <= e;
        cmd(8'h06, 8'h00);
        eng <= '0;
        chk(32'(ct), 32'h0);
        rd(8'h04, 8'h02);
        rd(8'h20, 8'h58);
        rd(8'h14, 8'h10);
        chk(32'(dma), 32'h1);
        e = '0;
        e.xfer_done = 1'b1;
        ev(e);
        rd(8'h1c, 8'h00);
        rd(8'h04, 8'h03);
        rd(8'h20, 8'h50);
        $display("direct test done");
    endtask
    task results;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("SIMULATION PASSED");
        end else begin
            $display("SIMULATION FAILED");
        end
        $finish;
    endtask
    // main sequence
    initial begin
        SYS_RST = 1'b1;
        oq = 1'b0;
        eng = '0;
        qa_seen = 1'b0;
        repeat (12) @(posedge CLK);
        SYS_RST <= 1'b0;
        rd(8'h20, 8'h40);
        rd(8'h1c, 8'h00);
        t_abort;
        t_release;
        t_error;
        t_direct;
        results;
    end
    // watchdog, far beyond the few hundred cycles the tests need
    initial begin
        #200000;
        error_cnt++;
        results;
    end
endmodule
